// >>> design/lps_pkg.sv
package lps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STEP_TIME_NS = 2720000;
   localparam int STEP_CYC_DEF = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam int PULSE_PERIOD_NS = 16000;
   localparam int PULSE_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int LED_ON_NS = 7200;
   localparam int LED_ON_CYC = (LED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LONG_WAIT_MULT = 12;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ATIME = 8'h04;
   localparam logic [7:0] A_WTIME = 8'h08;
   localparam logic [7:0] A_PPULSE = 8'h0C;
   localparam logic [7:0] A_ALS_THR = 8'h10;
   localparam logic [7:0] A_PROX_THR = 8'h14;
   localparam logic [7:0] A_PERS = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1C;
   localparam logic [7:0] A_INT_EN = 8'h20;
   localparam logic [7:0] A_INT_CLR = 8'h24;
   localparam logic [7:0] A_VIS_DATA = 8'h28;
   localparam logic [7:0] A_IR_DATA = 8'h2C;
   localparam logic [7:0] A_PROX_DATA = 8'h30;
   localparam logic [7:0] A_SEQ_STATE = 8'h34;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL_PON = 0;
   localparam int CTRL_ALS = 1;
   localparam int CTRL_PROX = 2;
   localparam int CTRL_WAIT = 3;
   localparam int WT_LONG = 8;
   localparam int ST_ALS_INT = 0;
   localparam int ST_PROX_INT = 1;
   localparam int ST_ALS_VALID = 2;
   localparam int ST_PROX_VALID = 3;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] ATIME_RST = 8'h24;
   localparam logic [8:0] WTIME_RST = 9'h000;
   localparam logic [7:0] PPULSE_RST = 8'h08;
   localparam logic [31:0] THR_RST = 32'hFFFF0000;
   localparam logic [7:0] PERS_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_PROX = 2'b01,
      ST_ALS = 2'b10,
      ST_WAIT = 2'b11
   } lps_state_e;

   function automatic logic [15:0] lps_sat_inc(input logic [15:0] v, input logic inc);
      lps_sat_inc = (inc && v != 16'hFFFF) ? v + 16'h0001 : v;
   endfunction : lps_sat_inc

endpackage : lps_pkg

// >>> design/lps_thr_if.sv
`timescale 1ns/1ps
interface lps_thr_if;
   logic [15:0] low;
   logic [15:0] high;
   logic [15:0] result;
   logic [3:0] pers;
   logic strobe;
   logic hit;
   modport seq (output low, high, result, pers, strobe, input hit);
   modport eval (input low, high, result, pers, strobe, output hit);
endinterface : lps_thr_if

// >>> design/lps_persist.sv
`timescale 1ns/1ps
module lps_persist
   import lps_pkg::*;
(
   // clock, reset, freeze
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // threshold channel
   lps_thr_if.eval t
);

   logic [3:0] cnt;
   wire out_win = (t.result < t.low) || (t.result > t.high);
   wire [3:0] next_cnt = out_win ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         cnt <= 4'h0;
         t.hit <= 1'b0;
      end
      else if (ce)
      begin
         if (t.strobe)
            cnt <= next_cnt;
         t.hit <= t.strobe && out_win && (next_cnt >= t.pers);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_hit_count;
      t.hit |-> (cnt != 4'h0) && (cnt >= t.pers);
   endproperty
   a_hit_count: assert property (p_hit_count) else $error("hit before persistence reached");

   property p_in_window_clears;
      ce && t.strobe && !out_win |=> (cnt == 4'h0) && !t.hit;
   endproperty
   a_in_window_clears: assert property (p_in_window_clears) else $error("in-window result kept count");

endmodule : lps_persist

// >>> design/lps_seq.sv
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - both channels integrate together, 16-bit saturating
// - both results latched into data together
// - proximity pulse train length 1 to 255
// - pulse period 16us, LED sink on 7.2us
// - sleep and wait states are low power
// - wait timer 2.72ms steps to over 8s
// - level interrupt held until software clears
// - out-of-window result is a trigger condition
// - threshold interrupts only after persistence count reached
// - separate thresholds and persistence per function
// - host reaches registers through slave port
module lps_seq
   import lps_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYC_DEF
)
(
   // clock, reset, freeze
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // converter charge pulses
   input wire logic visible_ir_channel,
   input wire logic ir_only_channel,
   input wire logic prox_channel,
   // led and power
   output logic led_driver_sink,
   output logic low_power,
   // interrupt
   output logic irq,
   output logic int_pin_o,
   output logic int_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] ctrl;
   logic [7:0] atime;
   logic [8:0] wtime;
   logic [7:0] ppulse;
   logic [31:0] als_thr;
   logic [31:0] prox_thr;
   logic [7:0] pers;
   logic [3:0] status;
   logic [3:0] int_en;
   logic [15:0] vis_data;
   logic [15:0] ir_data;
   logic [15:0] prox_data;

   // sequencer state
   lps_state_e state;
   lps_state_e next_state;
   logic [23:0] step_cnt;
   logic [11:0] step_idx;
   logic [10:0] phase;
   logic [7:0] pulse_idx;
   logic [15:0] acc_vis;
   logic [15:0] acc_ir;
   logic [15:0] acc_prox;

   lps_thr_if als_t ();
   lps_thr_if prox_t ();

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = req && wb_we_i;
   wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] rd_val =
      (wb_adr_i == A_CTRL) ? {28'h0, ctrl} :
      (wb_adr_i == A_ATIME) ? {24'h0, atime} :
      (wb_adr_i == A_WTIME) ? {23'h0, wtime} :
      (wb_adr_i == A_PPULSE) ? {24'h0, ppulse} :
      (wb_adr_i == A_ALS_THR) ? als_thr :
      (wb_adr_i == A_PROX_THR) ? prox_thr :
      (wb_adr_i == A_PERS) ? {24'h0, pers} :
      (wb_adr_i == A_STATUS) ? {28'h0, status} :
      (wb_adr_i == A_INT_EN) ? {28'h0, int_en} :
      (wb_adr_i == A_VIS_DATA) ? {16'h0, vis_data} :
      (wb_adr_i == A_IR_DATA) ? {16'h0, ir_data} :
      (wb_adr_i == A_PROX_DATA) ? {16'h0, prox_data} :
      (wb_adr_i == A_SEQ_STATE) ? {29'h0, low_power, state} : 32'h0;
   wire [31:0] merged = (rd_val & ~bmask) | (wb_dat_i & bmask);
   wire [3:0] clr_vec = (wr && wb_adr_i == A_INT_CLR) ? merged[3:0] : 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer decode
   wire step_tick = (step_cnt == 24'(STEP_CYC - 1));
   wire phase_end = (phase == 11'(PULSE_CYC - 1));
   wire [11:0] als_steps = {4'h0, atime} + 12'h001;
   wire [11:0] wait_base = {4'h0, wtime[7:0]} + 12'h001;
   wire [11:0] wait_steps = wtime[WT_LONG] ? 12'(wait_base * 12'(LONG_WAIT_MULT)) : wait_base;
   wire [11:0] wait_len = ctrl[CTRL_WAIT] ? wait_steps : 12'h001;
   wire [7:0] n_pulses = (ppulse == 8'h00) ? 8'h01 : ppulse;
   wire prox_done = (state == ST_PROX) && phase_end && (pulse_idx == n_pulses - 8'h01);
   wire als_done = (state == ST_ALS) && step_tick && (step_idx == als_steps - 12'h001);
   wire wait_done = (state == ST_WAIT) && step_tick && (step_idx == wait_len - 12'h001);
   wire leave = (next_state != state);
   wire sleeping = (state == ST_SLEEP);
   wire als_upd = als_done && ce;
   lps_state_e start_st;
   lps_state_e after_prox;
   assign start_st = ctrl[CTRL_PROX] ? ST_PROX : (ctrl[CTRL_ALS] ? ST_ALS : ST_WAIT);
   assign after_prox = ctrl[CTRL_ALS] ? ST_ALS : ST_WAIT;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_SLEEP:
            if (ctrl[CTRL_PON])
               next_state = start_st;
         ST_PROX:
            if (prox_done)
               next_state = after_prox;
         ST_ALS:
            if (als_done)
               next_state = ST_WAIT;
         ST_WAIT:
            if (wait_done)
               next_state = start_st;
      endcase
      if (!ctrl[CTRL_PON])
         next_state = ST_SLEEP;
   end

   ////////////////////////////////////////////////////////////////////////////
   // threshold channels
   assign als_t.low = als_thr[15:0];
   assign als_t.high = als_thr[31:16];
   assign als_t.pers = pers[3:0];
   assign als_t.result = acc_vis;
   assign als_t.strobe = als_done;
   assign prox_t.low = prox_thr[15:0];
   assign prox_t.high = prox_thr[31:16];
   assign prox_t.pers = pers[7:4];
   assign prox_t.result = acc_prox;
   assign prox_t.strobe = prox_done;

   lps_persist u_als_pers (
      .clock(clock),
      .rstn(rstn),
      .ce(ce),
      .t(als_t.eval)
   );

   lps_persist u_prox_pers (
      .clock(clock),
      .rstn(rstn),
      .ce(ce),
      .t(prox_t.eval)
   );

   wire [3:0] set_vec = {prox_done, als_done, prox_t.hit, als_t.hit};
   wire [3:0] next_status = (status & ~clr_vec) | set_vec;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave and registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl <= CTRL_RST;
         atime <= ATIME_RST;
         wtime <= WTIME_RST;
         ppulse <= PPULSE_RST;
         als_thr <= THR_RST;
         prox_thr <= THR_RST;
         pers <= PERS_RST;
         int_en <= 4'h0;
      end
      else if (ce)
      begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_val : wb_dat_o;
         if (wr && wb_adr_i == A_CTRL)
            ctrl <= merged[3:0];
         if (wr && wb_adr_i == A_ATIME)
            atime <= merged[7:0];
         if (wr && wb_adr_i == A_WTIME)
            wtime <= merged[8:0];
         if (wr && wb_adr_i == A_PPULSE)
            ppulse <= merged[7:0];
         if (wr && wb_adr_i == A_ALS_THR)
            als_thr <= merged;
         if (wr && wb_adr_i == A_PROX_THR)
            prox_thr <= merged;
         if (wr && wb_adr_i == A_PERS)
            pers <= merged[7:0];
         if (wr && wb_adr_i == A_INT_EN)
            int_en <= merged[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status and interrupt
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         status <= 4'h0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         status <= next_status;
         irq <= |(next_status & int_en);
      end
   end

   assign int_pin_o = 1'b0;
   assign int_pin_oe = irq;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         state <= ST_SLEEP;
         step_cnt <= 24'h0;
         step_idx <= 12'h0;
         phase <= 11'h0;
         pulse_idx <= 8'h0;
         led_driver_sink <= 1'b0;
         low_power <= 1'b1;
      end
      else if (ce)
      begin
         state <= next_state;
         step_cnt <= (leave || step_tick || sleeping) ? 24'h0 : step_cnt + 24'h1;
         step_idx <= leave ? 12'h0 : (step_tick ? step_idx + 12'h1 : step_idx);
         phase <= (leave || phase_end || state != ST_PROX) ? 11'h0 : phase + 11'h1;
         pulse_idx <= leave ? 8'h0 : (phase_end ? pulse_idx + 8'h1 : pulse_idx);
         led_driver_sink <= (state == ST_PROX) && !leave && (phase < 11'(LED_ON_CYC));
         low_power <= (next_state == ST_SLEEP) || (next_state == ST_WAIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // converters and data registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         acc_vis <= 16'h0;
         acc_ir <= 16'h0;
         acc_prox <= 16'h0;
         vis_data <= 16'h0;
         ir_data <= 16'h0;
         prox_data <= 16'h0;
      end
      else if (ce)
      begin
         acc_vis <= (state == ST_ALS && !leave) ? lps_sat_inc(acc_vis, visible_ir_channel) : 16'h0;
         acc_ir <= (state == ST_ALS && !leave) ? lps_sat_inc(acc_ir, ir_only_channel) : 16'h0;
         acc_prox <= (state == ST_PROX && !leave) ? lps_sat_inc(acc_prox, prox_channel && led_driver_sink) : 16'h0;
         if (als_done)
         begin
            vis_data <= acc_vis;
            ir_data <= acc_ir;
         end
         if (prox_done)
            prox_data <= acc_prox;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [10:0] on_run;
   always_ff @(posedge clock)
   begin
      if (!rstn)
         on_run <= 11'h0;
      else if (ce)
         on_run <= led_driver_sink ? on_run + 11'h1 : 11'h0;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_led_width;
      on_run <= 11'(LED_ON_CYC);
   endproperty
   a_led_width: assert property (p_led_width) else $error("led on longer than 7.2us");

   property p_led_in_prox;
      led_driver_sink |-> state == ST_PROX;
   endproperty
   a_led_in_prox: assert property (p_led_in_prox) else $error("led on outside proximity");

   property p_pulse_count;
      state == ST_PROX |-> pulse_idx < n_pulses;
   endproperty
   a_pulse_count: assert property (p_pulse_count) else $error("too many led pulses");

   property p_pair;
      $changed(vis_data) || $changed(ir_data) |-> $past(als_upd);
   endproperty
   a_pair: assert property (p_pair) else $error("channel data updated apart");

   property p_low_power;
      ce && (next_state == ST_WAIT || next_state == ST_SLEEP) |=> low_power;
   endproperty
   a_low_power: assert property (p_low_power) else $error("no low power between measurements");

   property p_wait_len;
      state == ST_WAIT |-> step_idx < wait_len;
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("wait overran");

   property p_sticky;
      ce && status[ST_ALS_INT] && !clr_vec[ST_ALS_INT] |=> status[ST_ALS_INT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost without clear");

   property p_irq;
      ce && |(status & int_en & ~clr_vec) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled status without interrupt");

   property p_pin;
      irq |-> int_pin_oe && !int_pin_o;
   endproperty
   a_pin: assert property (p_pin) else $error("interrupt pin not pulled low");

   property p_ack;
      ce && wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held two cycles");

   property p_cv_als;
      als_upd;
   endproperty
   c_als: cover property (p_cv_als);

   property p_cv_prox;
      prox_done && ce;
   endproperty
   c_prox: cover property (p_cv_prox);

   property p_cv_irq;
      $rose(irq);
   endproperty
   c_irq: cover property (p_cv_irq);

endmodule : lps_seq

// >>> bench/lps_light_model.sv
`timescale 1ns/1ps
// far side: light source and reflecting target in front of the sensor
module lps_light_model
(
   // clock, reset
   input wire logic clock,
   input wire logic rstn,
   // scene control and led
   input wire logic light_on,
   input wire logic led_driver_sink,
   // charge pulses
   output logic visible_ir_channel,
   output logic ir_only_channel,
   output logic prox_channel
);
   logic phase;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         phase <= 1'b0;
      end
      else
      begin
         phase <= ~phase;
      end
   end

   // both photodiodes see the same light, so a matched pair must read equal
   assign visible_ir_channel = light_on & phase;
   assign ir_only_channel = light_on & phase;
   // reflected charge only while the led sink is on
   assign prox_channel = led_driver_sink & phase;
endmodule : lps_light_model

// >>> bench/tb_light_proximity_sensor_sequencer.sv
`timescale 1ns/1ps
module tb_light_proximity_sensor_sequencer
   import lps_pkg::*;
;
   localparam int STEP = 20;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic ack;
   logic vis, iro, prx, led, lp, irq, pin_o, pin_oe, int_wire;
   logic light_on = 1'b0;
   logic led_q = 1'b0;
   logic lp_q = 1'b0;
   int err_total = 0;
   int check_count = 0;
   int hi_cnt = 0;
   int last_hi = 0;
   int per_cnt = 0;
   int last_per = 0;
   int rises = 0;
   int lp_cnt = 0;
   int last_lp = 0;
   int lp_falls = 0;
   logic [31:0] q;
   logic [31:0] vis_d;
   logic [7:0] ra [8] = '{A_CTRL, A_ATIME, A_WTIME, A_PPULSE, A_ALS_THR, A_PERS, A_SEQ_STATE, 8'h3C};
   logic [31:0] re [8] = '{32'h0, 32'h24, 32'h0, 32'h08, 32'hFFFF0000, 32'h0, 32'h4, 32'h0};
   logic [7:0] pp [3] = '{8'h00, 8'h01, 8'h03};
   int pn [3] = '{1, 1, 3};

   always #4 clock = ~clock;

   // open-drain interrupt line with pull-up
   assign int_wire = pin_oe ? pin_o : 1'b1;

   lps_seq #(.STEP_CYC(STEP)) dut (.clock(clock), .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .visible_ir_channel(vis), .ir_only_channel(iro), .prox_channel(prx), .led_driver_sink(led),
      .low_power(lp), .irq(irq), .int_pin_o(pin_o), .int_pin_oe(pin_oe));

   lps_light_model far (.clock(clock), .rstn(rstn), .light_on(light_on), .led_driver_sink(led),
      .visible_ir_channel(vis), .ir_only_channel(iro), .prox_channel(prx));

   ////////////////////////////////////////////////////////////////////////////
   // led pulse and low-power run monitors
   always @(posedge clock)
   begin
      led_q <= led;
      lp_q <= lp;
      per_cnt <= (led && !led_q) ? 1 : per_cnt + 1;
      if (led && !led_q)
      begin
         rises <= rises + 1;
         last_per <= per_cnt;
      end
      hi_cnt <= led ? hi_cnt + 1 : 0;
      if (!led && led_q)
      begin
         last_hi <= hi_cnt;
      end
      lp_cnt <= lp ? lp_cnt + 1 : 0;
      if (!lp && lp_q)
      begin
         last_lp <= lp_cnt;
         lp_falls <= lp_falls + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus and compare tasks
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_total++;
         $display("MISMATCH bus ack expected 1 seen %b", ack);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_bit(input int b);
      int n;
      n = 0;
      do
      begin
         wb(1'b0, A_STATUS, 32'h0);
         n++;
      end while (q[b] !== 1'b1 && n < 3000);
      chk("status wait", 32'h1, {31'h0, q[b]});
   endtask : wait_bit

   task automatic conclude();
      if (err_total == 0 && check_count > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial
   begin
      #(8 * 60000);
      err_total++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // tests
   initial
   begin
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      chk("irq after reset", 32'h0, {31'h0, irq});
      for (int i = 0; i < 8; i++)
      begin
         wb(1'b0, ra[i], 32'h0);
         chk("reset value", re[i], q);
      end
      // writes to read-only and unmapped places are ignored
      wb(1'b1, A_STATUS, 32'hF);
      wb(1'b1, A_VIS_DATA, 32'h1234);
      wb(1'b1, 8'h3C, 32'h5A);
      wb(1'b0, A_STATUS, 32'h0);
      chk("status ro", 32'h0, q);
      wb(1'b0, A_VIS_DATA, 32'h0);
      chk("vis ro", 32'h0, q);
      wb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, q);
      // lit scene inside the window: matched pair, no trigger
      light_on <= 1'b1;
      wb(1'b1, A_ATIME, 32'h0);
      wb(1'b1, A_ALS_THR, 32'hFFFF0005);
      wb(1'b1, A_CTRL, 32'h3);
      wait_bit(ST_ALS_VALID);
      wb(1'b1, A_CTRL, 32'h0);
      wb(1'b0, A_VIS_DATA, 32'h0);
      vis_d = q;
      wb(1'b0, A_IR_DATA, 32'h0);
      chk("ir equals vis", vis_d, q);
      chk("vis nonzero", 32'h1, {31'h0, vis_d != 32'h0});
      wb(1'b0, A_STATUS, 32'h0);
      chk("no als trigger", 32'h0, {31'h0, q[ST_ALS_INT]});
      // dark scene below the window, persistence of three
      light_on <= 1'b0;
      wb(1'b1, A_PERS, 32'h3);
      wb(1'b1, A_INT_CLR, 32'hF);
      wb(1'b1, A_CTRL, 32'h3);
      for (int k = 1; k <= 3; k++)
      begin
         wait_bit(ST_ALS_VALID);
         // trigger bit lands one cycle after the valid bit, so read again
         wb(1'b0, A_STATUS, 32'h0);
         chk("persistence", {31'h0, k == 3}, {31'h0, q[ST_ALS_INT]});
         wb(1'b1, A_INT_CLR, 32'h4);
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, A_INT_EN, 32'h1);
      // irq follows the enable one edge after the write lands
      @(posedge clock);
      chk("irq enabled", 32'h1, {31'h0, irq});
      chk("pin pulled low", 32'h0, {31'h0, int_wire});
      wb(1'b1, A_INT_EN, 32'h0);
      @(posedge clock);
      chk("irq masked again", 32'h0, {31'h0, irq});
      wb(1'b1, A_INT_EN, 32'h1);
      wb(1'b1, A_CTRL, 32'h0);
      repeat (60) @(posedge clock);
      chk("irq held", 32'h1, {31'h0, irq});
      wb(1'b1, A_INT_CLR, 32'hF);
      wb(1'b0, A_SEQ_STATE, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      chk("pin released", 32'h1, {31'h0, int_wire});
      // proximity trains, prox window closed so every result is out
      wb(1'b1, A_PROX_THR, 32'h0);
      wb(1'b1, A_INT_EN, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b1, A_PPULSE, {24'h0, pp[i]});
         wb(1'b1, A_INT_CLR, 32'hF);
         rises = 0;
         wb(1'b1, A_CTRL, 32'h5);
         wait_bit(ST_PROX_VALID);
         wb(1'b1, A_CTRL, 32'h0);
         chk("pulse count", pn[i], rises);
         // reflected charge arrives on every other cycle while the sink is on
         wb(1'b0, A_PROX_DATA, 32'h0);
         chk("prox data", pn[i] * (LED_ON_CYC / 2), q);
         chk("led on time", LED_ON_CYC, last_hi);
         wb(1'b0, A_STATUS, 32'h0);
         chk("prox only trigger", 32'h2, {30'h0, q[1:0]});
      end
      chk("pulse period", PULSE_CYC, last_per);
      // wait timer, short and long steps
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, A_WTIME, i == 0 ? 32'h1 : 32'h101);
         lp_falls = 0;
         wb(1'b1, A_CTRL, 32'hB);
         wait (lp_falls >= 2);
         wb(1'b1, A_CTRL, 32'h0);
         chk("wait length", i == 0 ? 2 * STEP : 2 * LONG_WAIT_MULT * STEP, last_lp);
      end
      wb(1'b0, A_SEQ_STATE, 32'h0);
      chk("sleep state", 32'h4, q);
      conclude();
   end
endmodule : tb_light_proximity_sensor_sequencer
